// ---- hw/sac_pkg.sv ----
// Shared constants and types of the converter control block
package sac_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the bus)
  // ****************************************************************
  localparam int          ADDR_W    = 5;
  localparam logic [4:0]  OFF_CTRL  = 5'h00;
  localparam logic [4:0]  OFF_CHAN  = 5'h04;
  localparam logic [4:0]  OFF_STAT  = 5'h08;
  localparam logic [4:0]  OFF_RESL  = 5'h0C;
  localparam logic [4:0]  OFF_RESH  = 5'h10;
  localparam logic [4:0]  OFF_WINHI = 5'h14;
  localparam logic [4:0]  OFF_WINLO = 5'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_EN    = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_TRIG  = 2;
  localparam int CTRL_LJUST = 4;
  localparam int CTRL_CIE   = 5;
  localparam int CTRL_WIE   = 6;
  localparam int CTRL_WOUT  = 7;
  localparam int CTRL_REF   = 8;
  localparam int CTRL_W     = 9;
  localparam int CHAN_SEL   = 0;
  localparam int CHAN_DIFF  = 4;
  localparam int CHAN_GAIN  = 8;
  localparam int STAT_DONE  = 0;
  localparam int STAT_WIN   = 1;
  localparam int STAT_BUSY  = 2;

  // ****************************************************************
  // Values after reset and legal ranges
  // ****************************************************************
  localparam logic [8:0]  CTRL_RST  = 9'h000;
  localparam logic [3:0]  CHSEL_RST = 4'h0;
  localparam logic [3:0]  DIFF_RST  = 4'h0;
  localparam logic [2:0]  GAIN_RST  = 3'h1;
  localparam logic [15:0] WINHI_RST = 16'hFFFF;
  localparam logic [15:0] WINLO_RST = 16'h0000;
  localparam logic [3:0]  CHAN_TEMP = 4'h8;
  localparam logic [2:0]  GAIN_MAX  = 3'h5;

  typedef enum logic [1:0] {
    TRIG_SW  = 2'b00,
    TRIG_T2  = 2'b01,
    TRIG_T3  = 2'b10,
    TRIG_EXT = 2'b11
  } sac_trig_t;

  // Gain codes: 0.5, 1, 2, 4, 8, 16
  typedef enum logic [2:0] {
    GAIN_HALF = 3'h0,
    GAIN_X1   = 3'h1,
    GAIN_X2   = 3'h2,
    GAIN_X4   = 3'h3,
    GAIN_X8   = 3'h4,
    GAIN_X16  = 3'h5
  } sac_gain_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_TRACK = 2'b01,
    S_BIT   = 2'b10,
    S_DONE  = 2'b11
  } sac_state_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ   = 25000;
  localparam int TRACK_NS  = 1000;
  localparam int SETTLE_NS = 160;
  localparam int SYNC_LAT  = 2;

  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns * CLK_KHZ + 999999) / 1000000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TRACK_CYC  = cyc_ceil(TRACK_NS);
  localparam int SETTLE_CYC = cyc_ceil(SETTLE_NS);

endpackage

// ---- hw/sac_sar.sv ----
// Successive-approximation sequencer: track, then one trial per bit
module sac_sar
  import sac_pkg::*;
#(
  parameter int RES_W = 12
)(
  input  wire logic             CORE_CLK, // Core clock
  input  wire logic             RST_N,    // Async reset, active low
  input  wire logic             start,    // Begin a conversion
  input  wire logic             abort,    // Shutdown: drop to idle
  input  wire logic             comp,     // Synchronised comparator, 1 = input above trial
  output logic                  busy,     // Conversion in progress
  output logic                  track,    // Sample switch closed
  output logic [RES_W-1:0]      trial,    // Trial code for the capacitor DAC
  output logic                  done,     // One-cycle pulse, result valid
  output logic [RES_W-1:0]      result   // Final code
);
  localparam int WAIT_CYC = SETTLE_CYC + SYNC_LAT;

  if (RES_W != 10 && RES_W != 12) begin
    $error("RES_W must be 10 or 12");
  end

  sac_state_t       st_q, st_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [RES_W-1:0] trial_q, trial_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    bit_d   = bit_q;
    trial_d = trial_q;
    case (st_q)
      S_IDLE: begin
        if (start) begin
          st_d    = S_TRACK;
          cnt_d   = 8'(TRACK_CYC - 1);
          trial_d = '0;
        end
      end
      S_TRACK: begin
        if (cnt_q == 8'h00) begin
          st_d           = S_BIT;
          bit_d          = 4'(RES_W - 1);
          cnt_d          = 8'(WAIT_CYC - 1);
          trial_d        = '0;
          trial_d[RES_W-1] = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      S_BIT: begin
        if (cnt_q == 8'h00) begin
          // Keep the bit only while the input stays above the trial
          if (!comp) trial_d[bit_q] = 1'b0;
          if (bit_q == 4'h0) begin
            st_d = S_DONE;
          end else begin
            trial_d[bit_q - 4'h1] = 1'b1;
            bit_d = bit_q - 4'h1;
            cnt_d = 8'(WAIT_CYC - 1);
          end
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    if (abort) st_d = S_IDLE; // [R9]
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q    <= S_IDLE;
      cnt_q   <= 8'h00;
      bit_q   <= 4'h0;
      trial_q <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      trial_q <= trial_d;
    end
  end

  assign busy   = (st_q != S_IDLE);
  assign track  = (st_q == S_TRACK);
  assign trial  = trial_q;
  assign done   = (st_q == S_DONE);
  assign result = trial_q;

  property p_start_busy;
    @(posedge CORE_CLK) disable iff (!RST_N) (st_q == S_IDLE && start && !abort) |=> track;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not begin tracking"); // [R1]
endmodule

// ---- hw/sac_sync.sv ----
// Two-stage synchroniser with rising-edge pulse
module sac_sync
  import sac_pkg::*;
(
  input  wire logic CORE_CLK, // Core clock
  input  wire logic RST_N,    // Async reset, active low
  input  wire logic pin,      // Level from outside the domain
  output logic      level,    // Synchronised level
  output logic      rise      // One-cycle pulse on rising edge
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;

  property p_rise_single;
    @(posedge CORE_CLK) disable iff (!RST_N) rise |=> !rise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("edge pulse longer than one cycle"); // [R1]
endmodule

// ---- hw/sac_top.sv ----
// Control of the primary successive-approximation converter, APB slave
// ****************************************************************
// Overview of operation
// [R1] Start on software write, timer 2 overflow, timer 3 overflow or external edge.
// [R2] Completion sets a status flag; interrupt raised when completion interrupt enabled.
// [R3] Each finished result is latched into two byte-wide readable registers.
// [R4] Software chooses right or left alignment of the result in the pair.
// [R5] Window compare requests an interrupt for results inside or, optionally, outside.
// [R6] With only window interrupt enabled, background conversions interrupt on window hits only.
// [R7] Nine channels: temperature sensor plus eight external, pairs selectable differential.
// [R8] Amplifier gain selectable as 0.5, 1, 2, 4, 8 or 16.
// [R9] Software shutdown stops all conversion activity.
// [R10] Reference chosen between on-chip DAC output and external reference pin.
// [R11] Completion and window flags hold until software clears them.
// ****************************************************************
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module sac_top
  import sac_pkg::*;
#(
  parameter int RES_W = 12
)(
  input  wire logic              CORE_CLK,    // 25 MHz core clock
  input  wire logic              RST_N,       // Async reset, active low
  input  wire logic              PSEL,        // APB select
  input  wire logic              PENABLE,     // APB access phase
  input  wire logic              PWRITE,      // APB direction
  input  wire logic [ADDR_W-1:0] PADDR,       // APB byte address
  input  wire logic [31:0]       PWDATA,      // APB write data
  output logic      [31:0]       PRDATA,      // APB read data
  output logic                   PREADY,      // APB ready
  output logic                   PSLVERR,     // APB error, unmapped address
  input  wire logic              TMR2_OVF,    // Timer 2 overflow pulse
  input  wire logic              TMR3_OVF,    // Timer 3 overflow pulse
  input  wire logic              EXT_SOC,     // External start pin
  input  wire logic              COMP_IN,     // Analog comparator output
  output logic      [3:0]        AN_CHAN,     // Channel select, 8 = temperature
  output logic      [3:0]        AN_DIFF,     // Differential pair enables
  output logic      [2:0]        AN_GAIN,     // Amplifier gain code
  output logic                   AN_REF_EXT,  // 1 = external reference pin
  output logic                   AN_SHUTDOWN, // Analog section powered down
  output logic                   AN_TRACK,    // Sample switch closed
  output logic      [RES_W-1:0]  AN_TRIAL,    // Trial code
  output logic                   CONV_IRQ,    // Completion interrupt request
  output logic                   WIN_IRQ      // Window interrupt request
);

  if (RES_W != 10 && RES_W != 12) begin
    $error("RES_W must be 10 or 12");
  end

  // ****************************************************************
  // Justification
  // ****************************************************************
  function automatic logic [15:0] justify(input logic [RES_W-1:0] r, input logic left);
    logic [15:0] v;
    v = 16'(r);
    if (left) v = v << (16 - RES_W);
    return v;
  endfunction

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic [CTRL_W-1:0] ctrl_q,  ctrl_d;
  logic [3:0]        chsel_q, chsel_d;
  logic [3:0]        diff_q,  diff_d;
  logic [2:0]        gain_q,  gain_d;
  logic [15:0]       winhi_q, winhi_d;
  logic [15:0]       winlo_q, winlo_d;
  logic [15:0]       res_q,   res_d;
  logic              done_q,  done_d;
  logic              win_q,   win_d;
  logic              swst_q,  swst_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              err_q,   err_d;

  logic              wr, setup, mapped, fire, en;
  logic              ext_rise, comp_lvl;
  logic              sar_busy, sar_done;
  logic [RES_W-1:0]  sar_res;
  logic [15:0]       jres;
  logic              in_win, hit;
  sac_trig_t         trig;

  assign en    = ctrl_q[CTRL_EN];
  assign trig  = sac_trig_t'(ctrl_q[CTRL_TRIG +: 2]);
  assign wr    = PSEL & PENABLE & PWRITE;
  assign setup = PSEL & ~PENABLE;

  // ****************************************************************
  // Pin synchronisers and the sequencer
  // ****************************************************************
  sac_sync u_ext (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .pin      (EXT_SOC),
    .level    (),
    .rise     (ext_rise)
  );

  sac_sync u_cmp (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .pin      (COMP_IN),
    .level    (comp_lvl),
    .rise     ()
  );

  sac_sar #(.RES_W(RES_W)) u_sar (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .start    (fire),
    .abort    (~en),
    .comp     (comp_lvl),
    .busy     (sar_busy),
    .track    (AN_TRACK),
    .trial    (AN_TRIAL),
    .done     (sar_done),
    .result   (sar_res)
  );

  // ****************************************************************
  // Trigger selection
  // ****************************************************************
  // Triggers arriving while busy or shut down are dropped, not queued
  always_comb begin
    case (trig)
      TRIG_SW:  fire = swst_q;   // [R1]
      TRIG_T2:  fire = TMR2_OVF; // [R1]
      TRIG_T3:  fire = TMR3_OVF; // [R1]
      TRIG_EXT: fire = ext_rise; // [R1]
      default:  fire = 1'b0;
    endcase
    fire = fire & en & ~sar_busy; // [R9]
  end

  // ****************************************************************
  // Window comparator
  // ****************************************************************
  assign jres   = justify(sar_res, ctrl_q[CTRL_LJUST]);
  assign in_win = (jres >= winlo_q) && (jres <= winhi_q);
  assign hit    = ctrl_q[CTRL_WOUT] ? ~in_win : in_win; // [R5]

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb begin
    ctrl_d  = ctrl_q;
    chsel_d = chsel_q;
    diff_d  = diff_q;
    gain_d  = gain_q;
    winhi_d = winhi_q;
    winlo_d = winlo_q;
    res_d   = res_q;
    done_d  = done_q;
    win_d   = win_q;
    swst_d  = 1'b0;
    if (wr) begin
      case (PADDR)
        OFF_CTRL: begin
          ctrl_d             = PWDATA[CTRL_W-1:0];
          ctrl_d[CTRL_START] = 1'b0;
          swst_d             = PWDATA[CTRL_START]; // [R1]
        end
        OFF_CHAN: begin
          // Out-of-range codes are ignored so the mux never sees them
          if (PWDATA[CHAN_SEL +: 4] <= CHAN_TEMP) chsel_d = PWDATA[CHAN_SEL +: 4]; // [R7]
          diff_d = PWDATA[CHAN_DIFF +: 4]; // [R7]
          if (PWDATA[CHAN_GAIN +: 3] <= GAIN_MAX) gain_d = PWDATA[CHAN_GAIN +: 3]; // [R8]
        end
        OFF_STAT: begin
          if (PWDATA[STAT_DONE]) done_d = 1'b0;
          if (PWDATA[STAT_WIN])  win_d  = 1'b0;
        end
        OFF_WINHI: winhi_d = PWDATA[15:0];
        OFF_WINLO: winlo_d = PWDATA[15:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    if (sar_done) begin
      done_d = 1'b1;          // [R2] [R11]
      res_d  = jres;          // [R3] [R4]
      if (hit) win_d = 1'b1;  // [R5] [R11]
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle
  always_comb begin
    mapped  = 1'b1;
    rdata_d = 32'h0000_0000;
    case (PADDR)
      OFF_CTRL:  rdata_d = 32'(ctrl_q);
      OFF_CHAN:  rdata_d = 32'({gain_q, diff_q, chsel_q});
      OFF_STAT:  rdata_d = 32'({sar_busy, win_q, done_q});
      OFF_RESL:  rdata_d = 32'(res_q[7:0]);  // [R3]
      OFF_RESH:  rdata_d = 32'(res_q[15:8]); // [R3]
      OFF_WINHI: rdata_d = 32'(winhi_q);
      OFF_WINLO: rdata_d = 32'(winlo_q);
      default:   mapped  = 1'b0;
    endcase
    if (!setup) rdata_d = rdata_q;
    err_d = setup ? ~mapped : err_q;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q  <= CTRL_RST;
      chsel_q <= CHSEL_RST;
      diff_q  <= DIFF_RST;
      gain_q  <= GAIN_RST;
      winhi_q <= WINHI_RST;
      winlo_q <= WINLO_RST;
      res_q   <= 16'h0000;
      done_q  <= 1'b0;
      win_q   <= 1'b0;
      swst_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      chsel_q <= chsel_d;
      diff_q  <= diff_d;
      gain_q  <= gain_d;
      winhi_q <= winhi_d;
      winlo_q <= winlo_d;
      res_q   <= res_d;
      done_q  <= done_d;
      win_q   <= win_d;
      swst_q  <= swst_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PREADY      = 1'b1;
  assign PRDATA      = rdata_q;
  assign PSLVERR     = err_q & PSEL & PENABLE;
  assign AN_CHAN     = chsel_q;              // [R7]
  assign AN_DIFF     = diff_q;               // [R7]
  assign AN_GAIN     = gain_q;               // [R8]
  assign AN_REF_EXT  = ctrl_q[CTRL_REF];     // [R10]
  assign AN_SHUTDOWN = ~en;                  // [R9]
  // Each request is gated by its own enable only, so background runs stay quiet
  assign CONV_IRQ    = done_q & ctrl_q[CTRL_CIE]; // [R2] [R6]
  assign WIN_IRQ     = win_q & ctrl_q[CTRL_WIE];  // [R5] [R6]

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_conv_end;
    sar_done ##1 done_q;
  endsequence

  property p_trig_t2;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (en && !sar_busy && trig == TRIG_T2 && TMR2_OVF) |=> sar_busy;
  endproperty
  a_trig_t2: assert property (p_trig_t2) else $error("timer 2 overflow did not start"); // [R1]

  property p_done_flag;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (sar_done && ctrl_q[CTRL_CIE] && !(wr && PADDR == OFF_CTRL)) |-> s_conv_end ##0 CONV_IRQ;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion flag or request missing"); // [R2]

  property p_result;
    @(posedge CORE_CLK) disable iff (!RST_N)
      sar_done |=> res_q == justify($past(sar_res), $past(ctrl_q[CTRL_LJUST]));
  endproperty
  a_result: assert property (p_result) else $error("result pair not latched"); // [R3]

  property p_left;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (sar_done && ctrl_q[CTRL_LJUST]) |=> res_q[15 - RES_W:0] == '0;
  endproperty
  a_left: assert property (p_left) else $error("left aligned result has low bits set"); // [R4]

  property p_window;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (sar_done && hit && ctrl_q[CTRL_WIE] && !(wr && PADDR == OFF_CTRL)) |=> WIN_IRQ;
  endproperty
  a_window: assert property (p_window) else $error("window hit without request"); // [R5]

  property p_quiet;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (!ctrl_q[CTRL_CIE] && sar_done && !hit && !win_q && !(wr && PADDR == OFF_CTRL)) |=> !CONV_IRQ && !WIN_IRQ;
  endproperty
  a_quiet: assert property (p_quiet) else $error("background miss raised a request"); // [R6]

  property p_chan;
    @(posedge CORE_CLK) disable iff (!RST_N) AN_CHAN <= CHAN_TEMP && AN_GAIN <= GAIN_MAX;
  endproperty
  a_chan: assert property (p_chan) else $error("illegal channel or gain code"); // [R7]

  property p_gain_write;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (wr && PADDR == OFF_CHAN && PWDATA[CHAN_GAIN +: 3] <= GAIN_MAX) |=> AN_GAIN == $past(PWDATA[CHAN_GAIN +: 3]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain write not applied"); // [R8]

  property p_shutdown;
    @(posedge CORE_CLK) disable iff (!RST_N) !en |=> !sar_busy && !AN_TRACK;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("conversion active in shutdown"); // [R9]

  property p_ref;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (wr && PADDR == OFF_CTRL) |=> AN_REF_EXT == $past(PWDATA[CTRL_REF]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not applied"); // [R10]

  property p_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (done_q && !(wr && PADDR == OFF_STAT && PWDATA[STAT_DONE])) |=> done_q;
  endproperty
  a_hold: assert property (p_hold) else $error("completion flag cleared itself"); // [R11]
endmodule

// ---- tb/sac_analog.sv ----
// Behavioural analog comparator facing the converter's trial code
// ****************************************************************
// Comparator model
// ****************************************************************
module sac_analog
  import sac_pkg::*;
#(
  parameter int RES_W = 12
)(
  input  wire logic [RES_W-1:0] trial, // Trial code from the sequencer
  input  wire logic [RES_W-1:0] vin,   // Input level in codes
  output logic                  comp   // 1 = input above trial
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half-code offset keeps the decision clear of an equality tie
  assign comp = {vin, 1'b1} > {trial, 1'b0};
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the converter control block
module testbench
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic              clk, rst_n, psel, penable, pwrite, t2, t3, ext, pready, pslverr, comp, err_q;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, st_busy;
  logic [11:0]       vin, an_trial;
  logic [3:0]        an_chan, an_diff;
  logic [2:0]        an_gain;
  logic              an_ref, an_shut, an_track, conv_irq, win_irq;
  int                n_errors, compares;

  sac_top #(.RES_W(12)) DUT (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TMR2_OVF(t2),
    .TMR3_OVF(t3), .EXT_SOC(ext), .COMP_IN(comp), .AN_CHAN(an_chan), .AN_DIFF(an_diff), .AN_GAIN(an_gain),
    .AN_REF_EXT(an_ref), .AN_SHUTDOWN(an_shut), .AN_TRACK(an_track), .AN_TRIAL(an_trial),
    .CONV_IRQ(conv_irq), .WIN_IRQ(win_irq));
  sac_analog #(.RES_W(12)) u_an (.trial(an_trial), .vin(vin), .comp(comp));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out;
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    logic [31:0] q;
    apb(1, a, d, q);
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, output logic [31:0] q);
    apb(0, a, 0, q);
  endtask

  task automatic trig(logic [1:0] k);
    @(posedge clk);
    t2 <= (k == 1);
    t3 <= (k == 2);
    ext <= (k == 3);
    @(posedge clk);
    t2 <= 0;
    t3 <= 0;
    repeat (3) @(posedge clk);
    ext <= 0;
  endtask

  // Waits for busy first, so a sticky done from before cannot end the wait early
  task automatic conv(logic [31:0] ctrl, logic [11:0] v);
    logic [31:0] q;
    vin <= v;
    wr(OFF_CTRL, ctrl | (ctrl[3:2] == 0 ? 32'h2 : 32'h0));
    if (ctrl[3:2] != 0) trig(ctrl[3:2]);
    q = 0;
    for (int i = 0; i < 40 && q[2] !== 1'b1; i++) rd(OFF_STAT, q);
    st_busy = q;
    chk("busy", 1, q[2]);
    chk("track", 1, an_track);
    for (int i = 0; i < 150 && q[2:0] !== 3'b001 && q[2:0] !== 3'b011; i++) rd(OFF_STAT, q);
    chk("done", 1, q[0]);
    @(negedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] q;
    rd(OFF_CTRL, q);
    chk("ctrl", 0, q);
    rd(OFF_CHAN, q);
    chk("chan", 32'h100, q);
    rd(OFF_WINHI, q);
    chk("winhi", 32'hFFFF, q);
    rd(OFF_WINLO, q);
    chk("winlo", 0, q);
    chk("shutdown", 1, an_shut);
    rd(5'h1C, q);
    chk("unmapped err", 1, err_q);
    chk("unmapped data", 0, q);
  endtask

  task automatic t_sw;
    logic [31:0] q;
    conv(32'h21, 12'hABC);
    chk("conv irq", 1, conv_irq);
    rd(OFF_RESL, q);
    chk("resl", 32'hBC, q);
    rd(OFF_RESH, q);
    chk("resh", 32'h0A, q);
    conv(32'h21, 12'h123);
    chk("done kept", 1, st_busy[0]);
    wr(OFF_STAT, 3);
    @(negedge clk);
    chk("irq cleared", 0, conv_irq);
    conv(32'h31, 12'hABC);
    rd(OFF_RESL, q);
    chk("left resl", 32'hC0, q);
    rd(OFF_RESH, q);
    chk("left resh", 32'hAB, q);
  endtask

  task automatic t_trig;
    logic [31:0] q;
    for (int k = 1; k < 4; k++) begin
      wr(OFF_STAT, 3);
      conv(32'h1 | (k << 2), 12'h5A0 + k[11:0]);
      rd(OFF_RESL, q);
      chk("trig resl", 32'hA0 + k, q);
    end
  endtask

  task automatic t_win;
    logic [11:0] vs[5] = '{12'h150, 12'h300, 12'h200, 12'h0FF, 12'h300};
    logic [31:0] cs[5] = '{32'h45, 32'h45, 32'h45, 32'h45, 32'hC5};
    logic        ex[5] = '{1, 0, 1, 0, 1};
    wr(OFF_WINLO, 32'h100);
    wr(OFF_WINHI, 32'h200);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_STAT, 3);
      conv(cs[i], vs[i]);
      chk("win irq", ex[i], win_irq);
      chk("no conv irq", 0, conv_irq);
    end
  endtask

  task automatic t_shut;
    logic [31:0] q;
    wr(OFF_STAT, 3);
    wr(OFF_CTRL, 32'h3);
    rd(OFF_STAT, q);
    chk("running", 1, q[2]);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STAT, q);
    chk("aborted", 0, q);
    chk("track off", 0, an_track);
    wr(OFF_CTRL, 32'h2);
    for (int i = 0; i < 60; i++) rd(OFF_STAT, q);
    chk("no conversion", 0, q);
    chk("shutdown", 1, an_shut);
  endtask

  task automatic t_mux;
    for (int g = 0; g < 6; g++) begin
      wr(OFF_CHAN, (g << 8) | 32'hA8);
      @(negedge clk);
      chk("gain", g, an_gain);
    end
    chk("chan", 8, an_chan);
    chk("diff", 4'hA, an_diff);
    wr(OFF_CHAN, 32'h0609);
    @(negedge clk);
    chk("chan kept", 8, an_chan);
    chk("gain kept", 5, an_gain);
    wr(OFF_CTRL, 32'h101);
    @(negedge clk);
    chk("ref ext", 1, an_ref);
    chk("powered", 0, an_shut);
    wr(OFF_CTRL, 32'h001);
    @(negedge clk);
    chk("ref dac", 0, an_ref);
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    {rst_n, psel, penable, pwrite, t2, t3, ext} = 0;
    paddr = 0;
    pwdata = 0;
    vin = 0;
    n_errors = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_sw();
    t_trig();
    t_win();
    t_shut();
    t_mux();
    close_out();
  end

  // About 1500 cycles expected; allow about sixteen times that (25000 cycles)
  initial begin
    #1000000;
    n_errors++;
    close_out();
  end
endmodule
